//--- src/cpf_framer.sv
// Command packet framer: splits the host byte stream into packets, checks sums,
// and applies the masked parameter updates of an accepted packet.
// Assumes the USB endpoint logic delivers bytes on i_clk with valid/ready.
`timescale 1ns/1ns
module cpf_framer #(
  parameter int DEPTH = cpf_pkg::CPF_FIFO_DEPTH
) (
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_rx_valid,
  output logic             o_rx_ready,
  input  wire logic [7:0]  i_rx_data,
  output logic             o_tx_valid,
  input  wire logic        i_tx_ready,
  output logic [7:0]       o_tx_data,
  output logic             o_pkt_ok,
  output logic             o_pkt_bad,
  output logic             o_pkt_ext,
  output logic [7:0]       o_pkt_cmd,
  output logic [7:0]       o_pkt_words,
  output logic             o_pkt_target,
  input  wire logic        i_apply,
  input  wire logic [7:0]  i_update_select_mask,
  input  wire logic [15:0] i_analog_value,
  input  wire logic [7:0]  i_line_update_mask,
  input  wire logic [7:0]  i_line_direction_byte,
  input  wire logic [7:0]  i_line_state_byte,
  output logic [15:0]      o_analog_channel_select,
  output logic [7:0]       o_line_dir,
  output logic [7:0]       o_line_out
);
  import cpf_pkg::*;

  typedef struct packed {
    cpf_state_type st;
    logic [7:0]    idx;
    logic [7:0]    len;
    logic          ext;
    logic [7:0]    cmd;
    logic [7:0]    words;
    logic          target;
    logic [7:0]    sum8_rx;
    logic [15:0]   sum16_rx;
    logic [15:0]   acc8;
    logic [15:0]   acc16;
    logic          ok;
    logic          bad;
    logic [7:0]    tx_data;
    logic [15:0]   ain_sel;
    logic [7:0]    dir;
    logic [7:0]    outv;
    logic [1:0]    sent;
  } cpf_frm_st_type;

  cpf_frm_st_type st_reg;
  cpf_frm_st_type st_next;
  logic           take;
  logic [7:0]     byte_in;
  logic [7:0]     fold8;
  logic           sums_ok;

  cpf_stream_if #(.WIDTH(8)) rx_in ();
  cpf_stream_if #(.WIDTH(8)) rx_buf ();

  assign rx_in.valid = i_rx_valid;
  assign rx_in.data  = i_rx_data;
  assign o_rx_ready  = rx_in.ready;

  cpf_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .s_in     (rx_in),
    .s_out    (rx_buf)
  );

  // One's-complement add of one byte into a 16-bit accumulator
  function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [7:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {9'h000, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction : oc_add

  // Two folds of high byte into low byte give the 8-bit sum
  function automatic logic [7:0] fold(input logic [15:0] a);
    logic [15:0] f;
    f = {8'h00, a[15:8]} + {8'h00, a[7:0]};
    f = {8'h00, f[15:8]} + {8'h00, f[7:0]};
    return f[7:0];
  endfunction : fold

  // Command bits all ones select the extended layout
  function automatic logic is_ext_cmd(input logic [7:0] b);
    return (b[CPF_CMD_MSB:CPF_CMD_LSB] == CPF_EXT_CMD);
  endfunction : is_ext_cmd

  // Header plus two bytes a word; the 125-word maximum wraps to zero together with the index
  function automatic logic [7:0] pkt_len(input logic ext, input logic [6:0] words);
    return 8'((ext ? CPF_EXT_HDR_LEN : CPF_NORM_HDR_LEN) + {words, 1'b0});
  endfunction : pkt_len

  assign byte_in      = rx_buf.data;
  assign take         = rx_buf.valid && rx_buf.ready;
  assign rx_buf.ready = (st_reg.st == CPF_IDLE) || (st_reg.st == CPF_HDR) || (st_reg.st == CPF_DATA);
  assign fold8        = fold(st_reg.acc8);
  assign sums_ok      = (fold8 == st_reg.sum8_rx) && (!st_reg.ext || st_reg.acc16 == st_reg.sum16_rx);

  always_comb begin
    st_next     = st_reg;
    st_next.ok  = 1'b0;
    st_next.bad = 1'b0;
    case (st_reg.st)
      CPF_IDLE: begin
        if (take) begin
          st_next.sum8_rx = byte_in;
          st_next.acc8    = CPF_SUM_RESET;
          st_next.acc16   = CPF_SUM_RESET;
          st_next.idx     = 8'h01;
          st_next.st      = CPF_HDR;
        end
      end
      CPF_HDR: begin
        if (take) begin
          st_next.idx = st_reg.idx + 8'h01;
          if (st_reg.idx == 8'h01) begin
            st_next.acc8   = oc_add(st_reg.acc8, byte_in);
            st_next.target = byte_in[CPF_TARGET_BIT];
            st_next.ext    = is_ext_cmd(byte_in);
            st_next.cmd    = {4'h0, byte_in[CPF_CMD_MSB:CPF_CMD_LSB]};
            st_next.words  = {5'h00, byte_in[CPF_WCNT_MSB:0]};
            if (!is_ext_cmd(byte_in)) begin
              st_next.len = pkt_len(1'b0, {4'h0, byte_in[CPF_WCNT_MSB:0]});
              st_next.st  = (byte_in[CPF_WCNT_MSB:0] == 3'h0) ? CPF_CHECK : CPF_DATA;
            end
          end else begin
            st_next.acc8 = oc_add(st_reg.acc8, byte_in);
            if (st_reg.idx == CPF_IDX_EXT_WCNT) begin
              st_next.words = (byte_in > CPF_EXT_MAX_WORDS) ? CPF_EXT_MAX_WORDS : byte_in;
            end
            if (st_reg.idx == CPF_IDX_EXT_CMD) begin
              st_next.cmd = byte_in;
            end
            if (st_reg.idx == CPF_IDX_SUM16_LO) begin
              st_next.sum16_rx[7:0] = byte_in;
            end
            if (st_reg.idx == CPF_IDX_SUM16_HI) begin
              st_next.sum16_rx[15:8] = byte_in;
              st_next.len = pkt_len(1'b1, st_reg.words[6:0]);
              st_next.st  = (st_reg.words == 8'h00) ? CPF_CHECK : CPF_DATA;
            end
          end
        end
      end
      CPF_DATA: begin
        if (take) begin
          st_next.idx = st_reg.idx + 8'h01;
          if (st_reg.ext) begin
            st_next.acc16 = oc_add(st_reg.acc16, byte_in);
          end else begin
            st_next.acc8 = oc_add(st_reg.acc8, byte_in);
          end
          if (st_reg.idx + 8'h01 == st_reg.len) begin
            st_next.st = CPF_CHECK;
          end
        end
      end
      CPF_CHECK: begin
        if (sums_ok) begin
          st_next.ok = 1'b1;
          st_next.st = CPF_IDLE;
          if (i_apply) begin
            st_next.ain_sel = i_analog_value;
            for (int n = 0; n < 8; n++) begin
              if (i_line_update_mask[n]) begin
                st_next.dir[n]  = i_line_direction_byte[n];
                st_next.outv[n] = i_line_state_byte[n];
              end
            end
            if (!i_update_select_mask[0]) begin
              st_next.ain_sel = st_reg.ain_sel;
            end
          end
        end else begin
          st_next.bad     = 1'b1;
          st_next.tx_data = CPF_BAD_SUM_BYTE;
          st_next.st      = CPF_BAD0;
          st_next.sent    = 2'h0;
        end
      end
      CPF_BAD0: begin
        if (i_tx_ready) begin
          st_next.st   = CPF_BAD1;
          st_next.sent = st_reg.sent + 2'h1;
        end
      end
      CPF_BAD1: begin
        if (i_tx_ready) begin
          st_next.st   = CPF_IDLE;
          st_next.sent = st_reg.sent + 2'h1;
        end
      end
      default: begin
        st_next.st = CPF_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg         <= '0;
      st_reg.st      <= CPF_IDLE;
      st_reg.tx_data <= CPF_BYTE_RESET;
      st_reg.ain_sel <= CPF_AIN_RESET;
      st_reg.dir     <= CPF_LINE_RESET;
      st_reg.outv    <= CPF_LINE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_tx_valid              = (st_reg.st == CPF_BAD0) || (st_reg.st == CPF_BAD1);
  assign o_tx_data               = st_reg.tx_data;
  assign o_pkt_ok                = st_reg.ok;
  assign o_pkt_bad               = st_reg.bad;
  assign o_pkt_ext               = st_reg.ext;
  assign o_pkt_cmd               = st_reg.cmd;
  assign o_pkt_words             = st_reg.words;
  assign o_pkt_target            = st_reg.target;
  assign o_analog_channel_select = st_reg.ain_sel;
  assign o_line_dir              = st_reg.dir;
  assign o_line_out              = st_reg.outv;

  // Bad-sum reply is exactly two B8 bytes
  sequence bad_reply_s;
    o_tx_valid && o_tx_data == CPF_BAD_SUM_BYTE;
  endsequence

  bad_reply_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $rose(o_pkt_bad) |-> bad_reply_s) else $error("bad sum reply missing");
  no_apply_bad_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_pkt_bad |-> $stable(o_line_dir) && $stable(o_analog_channel_select)) else $error("bad packet acted on");
  ok_bad_excl_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !(o_pkt_ok && o_pkt_bad)) else $error("ok and bad together");
  ext_detect_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (st_reg.st == CPF_HDR && take && st_reg.idx == 8'h01) |=> (o_pkt_ext == ($past(byte_in[6:3]) == 4'hF)))
    else $error("extended detect wrong");
  norm_words_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !o_pkt_ext |-> o_pkt_words <= 8'h07) else $error("normal words above seven");
  ext_words_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (o_pkt_ext && st_reg.st == CPF_DATA) |-> o_pkt_words <= 8'h7D) else $error("extended words above limit");
  line_mask_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (o_pkt_ok && $past(i_line_update_mask) == 8'h00) |-> $stable(o_line_dir)) else $error("masked line changed");
  tx_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (o_tx_valid && !i_tx_ready) |=> o_tx_valid) else $error("reply dropped under stall");

  // Reply walks B8, B8, then idle; either byte may be held by a stall
  sequence first_taken_s;
    st_reg.st == CPF_BAD0 && o_tx_valid && i_tx_ready;
  endsequence

  sequence second_up_s;
    st_reg.st == CPF_BAD1 && o_tx_valid && o_tx_data == CPF_BAD_SUM_BYTE;
  endsequence

  sequence second_taken_s;
    st_reg.st == CPF_BAD1 && o_tx_valid && i_tx_ready;
  endsequence

  reply_second_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    first_taken_s |=> second_up_s)
    else $error("second reply byte missing");
  reply_end_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    second_taken_s |=> !o_tx_valid && st_reg.st == CPF_IDLE)
    else $error("reply longer than two bytes");
  reply_count_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $fell(o_tx_valid) |-> st_reg.sent == 2'h2)
    else $error("reply byte count not two");
  check_stall_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (st_reg.st == CPF_CHECK || o_tx_valid) |-> !rx_buf.ready)
    else $error("byte taken while checking or replying");

  // Header capture
  norm_len_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (st_reg.st == CPF_DATA && !st_reg.ext) |-> st_reg.len <= 8'h10)
    else $error("normal packet above sixteen bytes");
  norm_empty_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (st_reg.st == CPF_HDR && take && st_reg.idx == 8'h01 && byte_in[6:3] != 4'hF && byte_in[2:0] == 3'h0)
    |=> st_reg.st == CPF_CHECK)
    else $error("empty normal packet not checked at once");
  ext_empty_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (st_reg.st == CPF_HDR && take && st_reg.idx == CPF_IDX_SUM16_HI && st_reg.words == 8'h00)
    |=> st_reg.st == CPF_CHECK)
    else $error("empty extended packet not checked at once");
  cmd_range_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (o_pkt_ok && !o_pkt_ext) |-> o_pkt_cmd <= 8'h0E)
    else $error("normal command number above fourteen");
  target_bit_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (st_reg.st == CPF_HDR && take && st_reg.idx == 8'h01) |=> o_pkt_target == $past(byte_in[7]))
    else $error("target bit not captured");
  ext_cmd_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (st_reg.st == CPF_HDR && take && st_reg.idx == CPF_IDX_EXT_CMD) |=> o_pkt_cmd == $past(byte_in))
    else $error("extended command number not captured");
  sum_order_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (st_reg.st == CPF_HDR && take && st_reg.idx == CPF_IDX_SUM16_HI)
    |=> st_reg.sum16_rx == {$past(byte_in), $past(st_reg.sum16_rx[7:0])})
    else $error("payload sum bytes out of order");

  // Checksums
  sum8_match_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_pkt_ok |-> $past(fold8) == $past(st_reg.sum8_rx))
    else $error("header sum accepted without match");
  sum16_match_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (o_pkt_ok && o_pkt_ext) |-> $past(st_reg.acc16) == $past(st_reg.sum16_rx))
    else $error("payload sum accepted without match");
  hdr_sum_only_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (st_reg.st == CPF_DATA && st_reg.ext) |=> $stable(st_reg.acc8))
    else $error("extended payload entered header sum");
  norm_no_sum16_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (st_reg.st == CPF_DATA && !st_reg.ext) |=> $stable(st_reg.acc16))
    else $error("normal payload entered payload sum");
  ok_pulse_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_pkt_ok |=> !o_pkt_ok)
    else $error("accept pulse longer than one cycle");

  // Parameter updates land only with an accepted packet
  ain_write_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (o_pkt_ok && $past(i_apply) && $past(i_update_select_mask[0]))
    |-> o_analog_channel_select == $past(i_analog_value))
    else $error("analog select not written");
  ain_keep_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (o_pkt_ok && !($past(i_apply) && $past(i_update_select_mask[0]))) |-> $stable(o_analog_channel_select))
    else $error("analog select written without mask");
  line_dir_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (o_pkt_ok && $past(i_apply))
    |-> o_line_dir == (($past(o_line_dir) & ~$past(i_line_update_mask))
                     | ($past(i_line_direction_byte) & $past(i_line_update_mask))))
    else $error("line direction not applied per mask");
  line_out_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (o_pkt_ok && $past(i_apply))
    |-> o_line_out == (($past(o_line_out) & ~$past(i_line_update_mask))
                     | ($past(i_line_state_byte) & $past(i_line_update_mask))))
    else $error("line state not applied per mask");
  idle_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !o_pkt_ok |-> $stable(o_line_dir) && $stable(o_line_out) && $stable(o_analog_channel_select))
    else $error("parameter changed without a packet");
endmodule : cpf_framer

//--- src/cpf_pkg.sv
// Constants, types and field layout for the command packet framer.
// Assumes a byte stream from the USB endpoint logic, one byte per valid/ready beat.
// Operation
// - Normal packet: one command word plus zero to seven data words.
// - Extended packet: three command words plus zero to 125 data words.
// - Normal byte 1: target bit 7, command number bits 6-3, word count bits 2-0.
// - Normal byte 0 is the 8-bit sum of bytes 1 to packet end.
// - Command bits 6-3 all ones mark an extended packet, else normal.
// - Extended 16-bit sum covers byte 6 onward, carried low byte first in bytes 4-5.
// - Extended byte 0 is the 8-bit sum over header bytes 1 to 5.
// - Sums are one's-complement: each carry out is added back in.
// - 8-bit sum folds high byte into low byte, twice.
// - Target bit is accepted either way and changes nothing.
// - Multi-byte parameters are least significant byte first.
// - Update-select mask bit set overwrites parameter; clear bit only reads back.
// - Analog channel select is 16 bits; bit n acquires input n.
// - Line update mask bit set applies direction and state; clear bit only reads.
// - Line n maps to bit n; direction one is output, zero is input.
// - Any checksum mismatch replies B8 B8 and discards the command.
package cpf_pkg;
  localparam logic [3:0]  CPF_EXT_CMD       = 4'hF;
  localparam int          CPF_CMD_MSB       = 6;
  localparam int          CPF_CMD_LSB       = 3;
  localparam int          CPF_WCNT_MSB      = 2;
  localparam int          CPF_TARGET_BIT    = 7;
  localparam logic [7:0]  CPF_BAD_SUM_BYTE  = 8'hB8;
  localparam logic [7:0]  CPF_NORM_HDR_LEN  = 8'h02;
  localparam logic [7:0]  CPF_EXT_HDR_LEN   = 8'h06;
  localparam logic [7:0]  CPF_EXT_MAX_WORDS = 8'h7D;
  localparam logic [7:0]  CPF_IDX_EXT_WCNT  = 8'h02;
  localparam logic [7:0]  CPF_IDX_EXT_CMD   = 8'h03;
  localparam logic [7:0]  CPF_IDX_SUM16_LO  = 8'h04;
  localparam logic [7:0]  CPF_IDX_SUM16_HI  = 8'h05;
  localparam logic [15:0] CPF_SUM_RESET     = 16'h0000;
  localparam logic [7:0]  CPF_BYTE_RESET    = 8'h00;
  localparam logic [15:0] CPF_AIN_RESET     = 16'h0000;
  localparam logic [7:0]  CPF_LINE_RESET    = 8'h00;
  localparam int          CPF_FIFO_DEPTH    = 4;

  typedef enum logic [2:0] {
    CPF_IDLE  = 3'b000,
    CPF_HDR   = 3'b001,
    CPF_DATA  = 3'b011,
    CPF_CHECK = 3'b010,
    CPF_BAD0  = 3'b110,
    CPF_BAD1  = 3'b111
  } cpf_state_type;
endpackage : cpf_pkg

//--- src/cpf_stream_if.sv
// Byte stream carrier between the framer's own modules.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ns
interface cpf_stream_if #(parameter int WIDTH = 8);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : cpf_stream_if

//--- src/cpf_fifo.sv
// Small first-in first-out buffer for the incoming packet bytes.
// Assumes one clock; source and sink on the same domain.
`timescale 1ns/1ns
module cpf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic  i_clk,
  input  wire logic  i_arst_n,
  cpf_stream_if.snk  s_in,
  cpf_stream_if.src  s_out
);
  import cpf_pkg::*;
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } cpf_fifo_st_type;
  cpf_fifo_st_type  st_reg;
  cpf_fifo_st_type  st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign s_in.ready  = (st_reg.cnt != (AW+1)'(DEPTH));
  assign s_out.valid = (st_reg.cnt != '0);
  assign s_out.data  = mem[st_reg.rp];
  assign push        = s_in.valid && s_in.ready;
  assign pop         = s_out.valid && s_out.ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wp = (st_reg.wp == AW'(DEPTH-1)) ? '0 : st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = (st_reg.rp == AW'(DEPTH-1)) ? '0 : st_reg.rp + 1'b1;
    end
    if (push && !pop) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Memory has no reset; its output at rp is taken only while the count is nonzero
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[st_reg.wp] <= s_in.data;
    end
  end

  fifo_bound_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    st_reg.cnt <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : cpf_fifo

//--- verification/cpf_host_model.sv
// Host-side partner: streams queued command bytes and collects reply bytes.
// Assumes one clock; the bench fills tx_q, reads rx_q and sets slow for stalls.
`timescale 1ns/1ns
module cpf_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  output logic            o_valid,
  input  wire logic       i_ready,
  output logic [7:0]      o_data,
  input  wire logic       i_reply_valid,
  output logic            o_reply_ready,
  input  wire logic [7:0] i_reply_data
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  bit         slow = 1'b0;

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_valid       <= 1'b0;
      o_data        <= 8'h00;
      o_reply_ready <= 1'b0;
    end else begin
      if (i_reply_valid && o_reply_ready) begin
        rx_q.push_back(i_reply_data);
      end
      o_reply_ready <= slow ? 1'($urandom % 2) : 1'b1;
      if (o_valid && !i_ready) begin
        o_valid <= 1'b1;
      end else if (tx_q.size() > 0 && (!slow || $urandom % 3 != 0)) begin
        o_valid <= 1'b1;
        o_data  <= tx_q.pop_front();
      end else begin
        o_valid <= 1'b0;
        // No pull on the line, so idle shows a changing pattern rather than stale data
        o_data  <= ~o_data;
      end
    end
  end
endmodule : cpf_host_model

//--- verification/tb_top.sv
// Self-checking bench for the command packet framer with random and corner packets.
// Assumes the host model on the byte stream and the design package constants.
`timescale 1ns/1ns
module tb_top;
  import cpf_pkg::*;
  logic        i_clk;
  logic        i_arst_n;
  logic        i_apply;
  logic [7:0]  i_update_select_mask;
  logic [15:0] i_analog_value;
  logic [7:0]  i_line_update_mask;
  logic [7:0]  i_line_direction_byte;
  logic [7:0]  i_line_state_byte;
  logic        rx_valid, rx_ready, tx_valid, tx_ready;
  logic [7:0]  rx_data, tx_data;
  logic        pkt_ok, pkt_bad, pkt_ext, pkt_target;
  logic [7:0]  pkt_cmd, pkt_words, line_dir, line_out;
  logic [15:0] ain_sel;
  int          failures, checks, cyc;
  logic [7:0]  pk[$];
  logic [15:0] ain_e;
  logic [7:0]  dir_e, out_e;

  cpf_framer i_cpf_framer (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_rx_valid(rx_valid), .o_rx_ready(rx_ready),
    .i_rx_data(rx_data), .o_tx_valid(tx_valid), .i_tx_ready(tx_ready), .o_tx_data(tx_data), .o_pkt_ok(pkt_ok),
    .o_pkt_bad(pkt_bad), .o_pkt_ext(pkt_ext), .o_pkt_cmd(pkt_cmd), .o_pkt_words(pkt_words),
    .o_pkt_target(pkt_target), .i_apply(i_apply), .i_update_select_mask(i_update_select_mask),
    .i_analog_value(i_analog_value), .i_line_update_mask(i_line_update_mask),
    .i_line_direction_byte(i_line_direction_byte), .i_line_state_byte(i_line_state_byte),
    .o_analog_channel_select(ain_sel), .o_line_dir(line_dir), .o_line_out(line_out));
  cpf_host_model i_cpf_host_model (.i_clk(i_clk), .i_arst_n(i_arst_n), .o_valid(rx_valid), .i_ready(rx_ready),
    .o_data(rx_data), .i_reply_valid(tx_valid), .o_reply_ready(tx_ready), .i_reply_data(tx_data));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic end_sim;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : cmp_bit

  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : cmp_val

  function automatic logic [7:0] fold8(input logic [15:0] a);
    logic [15:0] s;
    s = {8'h00, a[15:8]} + {8'h00, a[7:0]};
    s = {8'h00, s[15:8]} + {8'h00, s[7:0]};
    return s[7:0];
  endfunction : fold8

  // Bad 1 spoils the header sum, bad 2 the last byte of the packet
  task automatic build(input bit ext, input logic [7:0] cmd, input int w, input int bad);
    logic [15:0] s;
    pk.delete();
    pk.push_back(8'h00);
    pk.push_back({1'($urandom), ext ? 4'hF : cmd[3:0], ext ? 3'($urandom) : 3'(w)});
    if (ext) begin
      pk.push_back(8'(w));
      pk.push_back(cmd);
      pk.push_back(8'h00);
      pk.push_back(8'h00);
    end
    for (int i = 0; i < 2 * w; i++) pk.push_back(8'($urandom));
    s = 16'h0000;
    for (int i = 6; ext && i < pk.size(); i++) s += {8'h00, pk[i]};
    if (ext) begin
      pk[4] = s[7:0];
      pk[5] = s[15:8];
    end
    s = 16'h0000;
    for (int i = 1; i < (ext ? 6 : pk.size()); i++) s += {8'h00, pk[i]};
    pk[0] = fold8(s);
    if (bad == 1) pk[0] ^= 8'h01;
    if (bad == 2) pk[pk.size() - 1] ^= 8'h80;
  endtask : build

  task automatic run(input bit ext, input logic [7:0] cmd, input int w, input int bad);
    int          n;
    logic        ap;
    logic [7:0]  um, lm, ld, ls;
    logic [15:0] av;
    build(ext, cmd, w, bad);
    ap = 1'($urandom);
    um = 8'($urandom);
    av = 16'($urandom);
    lm = ap ? 8'($urandom) : 8'h00;
    ld = 8'($urandom);
    ls = 8'($urandom);
    @(posedge i_clk);
    i_apply               <= ap;
    i_update_select_mask  <= um;
    i_analog_value        <= av;
    i_line_update_mask    <= lm;
    i_line_direction_byte <= ld;
    i_line_state_byte     <= ls;
    foreach (pk[i]) i_cpf_host_model.tx_q.push_back(pk[i]);
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (pkt_ok !== 1'b1 && pkt_bad !== 1'b1 && n < 3000);
    cmp_bit(pkt_ok, bad == 0, "ok");
    cmp_bit(pkt_bad, bad != 0, "bad");
    cmp_bit(tx_valid, bad != 0, "reply");
    if (bad == 0) begin
      cmp_bit(pkt_ext, ext, "ext");
      cmp_val(16'(pkt_cmd), ext ? {8'h00, cmd} : {12'h000, cmd[3:0]}, "cmd");
      cmp_val(16'(pkt_words), 16'(w), "words");
      cmp_bit(pkt_target, pk[1][7], "target");
      if (ap && um[0]) ain_e = av;
      if (ap) dir_e = (dir_e & ~lm) | (ld & lm);
      if (ap) out_e = (out_e & ~lm) | (ls & lm);
    end
    @(posedge i_clk);
    cmp_val(ain_sel, ain_e, "analog select");
    cmp_val(16'(line_dir), 16'(dir_e), "line dir");
    cmp_val(16'(line_out), 16'(out_e), "line out");
    n = 0;
    while (bad != 0 && i_cpf_host_model.rx_q.size() < 2 && n < 300) begin
      @(posedge i_clk);
      n++;
    end
    cmp_val(16'(i_cpf_host_model.rx_q.size()), bad != 0 ? 16'h0002 : 16'h0000, "reply count");
    foreach (i_cpf_host_model.rx_q[i]) cmp_val(16'(i_cpf_host_model.rx_q[i]), 16'h00B8, "reply");
    i_cpf_host_model.rx_q.delete();
  endtask : run

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      $display("[ERR] %0t timeout", $time);
      end_sim();
    end
  end

  initial begin
    bit ext;
    int w;
    void'($urandom(11));
    {i_arst_n, i_apply, i_update_select_mask, i_analog_value} = '0;
    {i_line_update_mask, i_line_direction_byte, i_line_state_byte} = '0;
    ain_e = CPF_AIN_RESET;
    dir_e = CPF_LINE_RESET;
    out_e = CPF_LINE_RESET;
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(posedge i_clk);
    cmp_bit(rx_ready, 1'b1, "ready after reset");
    cmp_bit(tx_valid | pkt_ok | pkt_bad, 1'b0, "idle after reset");
    cmp_val(ain_sel, CPF_AIN_RESET, "analog after reset");
    // Boundary counts first, then random traffic with stalls on both sides
    run(1'b0, 8'h00, 0, 0);
    run(1'b0, 8'h0E, 7, 0);
    run(1'b1, 8'h08, 0, 0);
    run(1'b1, 8'hFF, 125, 0);
    run(1'b0, 8'h05, 3, 1);
    run(1'b1, 8'h0B, 4, 2);
    run(1'b1, 8'h03, 0, 1);
    i_cpf_host_model.slow = 1'b1;
    repeat (30) begin
      ext = 1'($urandom);
      w = ext ? $urandom % 126 : $urandom % 8;
      run(ext, ext ? 8'($urandom) : 8'($urandom % 15), w, ($urandom % 4 == 0) ? 1 + $urandom % 2 : 0);
    end
    end_sim();
  end
endmodule : tb_top
